// ==== core/tsc_cmd_handler.sv ====
// Purpose: settings items and testfile upload command handler behind apb
// Assumes: one command at a time; flash writer shares pclk
// Notes: payload travels in a 32-byte buffer, byte k at bits 8k+7..8k
//
// Behaviour
// RL1: settings writes need unrestricted session; reads free
// RL2: post-test action 8 bits, 0 to 2
// RL3: system flags 16 bits, bit 0 month-first
// RL4: lock word 16 bits, bits 0-11 gate functions
// RL5: test choice policy 8 bits, 0 to 2
// RL6: fixed test index 0 to 19
// RL7: verdict label title, up to 30 characters
// RL8: product label title, up to 30 characters
// RL9: printer speed 0 or 1
// RL10: ten hand memory structures of 20 bytes
// RL11: ten hand memory names, up to 16 characters
// RL12: power-on memory choice 0 to 9
// RL13: clear command empties assembly; header must be zero
// RL14: host clears assembly before appending entries
// RL15: append adds record; needs prior clear
// RL16: host sends two to four strings
// RL17: bad header or strings give negative reply
// RL18: commit: interim reply, flash write, final reply
// RL19: query returns two bytes, bit 0 guard closed
// RL20: out-of-range write refused, value kept
//
// The APB interface to the registers and the address map were left to the implementer.
`include "tsc_defs.svh"
`timescale 1ns/1ps

module tsc_cmd_handler
	import tsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic guard_pin,
	output tsc_settings_t settings,
	output logic commit_req,
	input wire logic commit_done,
	input wire logic commit_ok,
	input wire logic [3:0] flash_rd_idx,
	output logic [255:0] flash_rd_rec,
	output logic [7:0] flash_rd_len,
	output logic [4:0] asm_count
);

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	// string check: length within limit, no null inside
	function automatic logic str_ok(input logic [255:0] b, input logic [7:0] len, input logic [7:0] lim);
		logic ok;
		ok = (len <= lim);
		for (int i = 0; i < 32; i++) begin
			if ((8'(i) < len) && (b[i*8 +: 8] == 8'h00)) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : str_ok

	// entry scan: null-terminated strings, each 1..limit long
	function automatic tsc_scan_t scan_entry(input logic [255:0] b, input logic [7:0] len);
		tsc_scan_t s;
		logic [7:0] run;
		s = '0;
		s.ok = 1'b1;
		run = 8'h00;
		for (int i = 0; i < 32; i++) begin
			if (8'(i) < len) begin
				if (b[i*8 +: 8] == 8'h00) begin
					if (run == 8'h00) begin
						s.ok = 1'b0;
					end
					s.count = s.count + 6'h01;
					run = 8'h00;
				end else begin
					run = run + 8'h01;
					if (run > `TSC_ENTRY_STR_MAX) begin
						s.ok = 1'b0;
					end
				end
			end
		end
		if ((run != 8'h00) || (s.count < `TSC_ENTRY_MIN) || (s.count > `TSC_ENTRY_MAX)) begin
			s.ok = 1'b0;
		end
		return s;
	endfunction : scan_entry

	// ----------------------------------------
	// state
	// ----------------------------------------
	tsc_state_t state_reg;
	tsc_reply_t reply_reg;
	logic [7:0] reason_reg;
	logic [7:0] reply_len_reg;
	logic free_reg;
	logic started_reg;
	logic [4:0] count_reg;
	logic [255:0] buf_reg;
	logic guard_meta_reg;
	logic guard_sync_reg;
	tsc_settings_t set_reg;
	logic [255:0] verdict_title_reg;
	logic [255:0] product_title_reg;
	logic [7:0] verdict_len_reg;
	logic [7:0] product_len_reg;
	logic [159:0] mem_set_reg [0:`TSC_MEM_COUNT-1];
	logic [127:0] mem_name_reg [0:`TSC_MEM_COUNT-1];
	logic [7:0] mem_len_reg [0:`TSC_MEM_COUNT-1];
	logic [255:0] asm_rec_mem [0:`TSC_ASM_DEPTH-1];
	logic [7:0] asm_len_mem [0:`TSC_ASM_DEPTH-1];

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire access = psel & penable & ce;
	wire setup = psel & ~penable & ce;
	wire hit_cmd = (paddr == `TSC_ADDR_CMD);
	wire hit_status = (paddr == `TSC_ADDR_STATUS);
	wire hit_session = (paddr == `TSC_ADDR_SESSION);
	wire hit_count = (paddr == `TSC_ADDR_ASM_COUNT);
	wire hit_buf = ((paddr & `TSC_ADDR_BUF_MASK) == `TSC_ADDR_BUF_BASE) & (paddr[1:0] == 2'b00);
	wire busy = (state_reg == TSC_ST_COMMIT);
	wire mapped = hit_cmd | hit_status | hit_session | hit_count | hit_buf;
	wire wr_refused = pwrite & busy & (hit_cmd | hit_buf);
	wire cmd_go = access & pwrite & hit_cmd & ~busy;
	wire buf_wr = access & pwrite & hit_buf & ~busy;
	wire [7:0] buf_bit = {paddr[4:2], 5'b00000};
	wire [31:0] status_word = {8'h00, reply_len_reg, reason_reg, 4'h0, started_reg, busy, reply_reg};
	wire [31:0] rd_word = hit_status ? status_word :
		hit_session ? {31'h00000000, free_reg} :
		hit_count ? {27'h0000000, count_reg} :
		hit_buf ? buf_reg[buf_bit +: 32] : 32'h00000000;

	assign pready = 1'b1;
	assign pslverr = access & (~mapped | wr_refused);

	// ----------------------------------------
	// command fields and payload views
	// ----------------------------------------
	wire tsc_cmd_t cmd = tsc_cmd_t'(pwdata);
	wire hdr_zero = (cmd.item == 8'h00) && (cmd.inst == 8'h00) && (cmd.len == 8'h00);
	wire [7:0] val8 = buf_reg[7:0];
	wire [15:0] val16 = {buf_reg[7:0], buf_reg[15:8]};
	wire item_known = (cmd.item >= `TSC_ITEM_ACTION) && (cmd.item <= `TSC_ITEM_POWER_ON);
	wire item_array = (cmd.item == `TSC_ITEM_MEM_SET) || (cmd.item == `TSC_ITEM_MEM_NAME);
	wire inst_bad = item_array ? (cmd.inst > `TSC_MEM_MAX) : (cmd.inst != 8'h00);
	wire [3:0] inst_idx = cmd.inst[3:0];
	wire len_byte = (cmd.len == `TSC_LEN_BYTE);
	wire tsc_scan_t scan = scan_entry(buf_reg, cmd.len);
	wire asm_full = (count_reg == `TSC_ASM_FULL);

	// value check per item on a set
	logic val_ok;
	always_comb begin
		unique case (cmd.item)
			// RL2: action 0..2
			`TSC_ITEM_ACTION: val_ok = len_byte && (val8 <= `TSC_ACTION_MAX);
			// RL3: 16-bit flags word
			`TSC_ITEM_SYS_FLAGS: val_ok = (cmd.len == `TSC_LEN_HALF);
			// RL4: 16-bit lock word
			`TSC_ITEM_LOCK: val_ok = (cmd.len == `TSC_LEN_HALF);
			// RL5: policy 0..2
			`TSC_ITEM_POLICY: val_ok = len_byte && (val8 <= `TSC_POLICY_MAX);
			// RL6: fixed index 0..19
			`TSC_ITEM_FIXED: val_ok = len_byte && (val8 <= `TSC_FIXED_MAX);
			// RL7: verdict title length
			`TSC_ITEM_VERDICT_TITLE: val_ok = str_ok(buf_reg, cmd.len, `TSC_TITLE_MAX);
			// RL8: product title length
			`TSC_ITEM_PRODUCT_TITLE: val_ok = str_ok(buf_reg, cmd.len, `TSC_TITLE_MAX);
			// RL9: printer speed 0..1
			`TSC_ITEM_PRINTER: val_ok = len_byte && (val8 <= `TSC_PRINTER_MAX);
			// RL10: exact 20-byte structure
			`TSC_ITEM_MEM_SET: val_ok = (cmd.len == `TSC_STRUCT_LEN);
			// RL11: name up to 16 characters
			`TSC_ITEM_MEM_NAME: val_ok = str_ok(buf_reg, cmd.len, `TSC_NAME_MAX);
			// RL12: memory choice 0..9
			`TSC_ITEM_POWER_ON: val_ok = len_byte && (val8 <= `TSC_MEM_MAX);
			default: val_ok = 1'b0;
		endcase
	end

	// verdict on the command just written
	logic nak;
	logic [7:0] why;
	always_comb begin
		nak = 1'b1;
		why = `TSC_WHY_NONE;
		unique case (cmd.op)
			`TSC_OP_GET: begin
				if (!item_known) why = `TSC_WHY_UNKNOWN;
				else if ((cmd.len != 8'h00) || inst_bad) why = `TSC_WHY_HEADER;
				else nak = 1'b0;
			end
			`TSC_OP_SET: begin
				if (!item_known) why = `TSC_WHY_UNKNOWN;
				// RL1: locked session refuses writes
				else if (!free_reg) why = `TSC_WHY_LOCKED;
				// RL20: bad instance or value refused
				else if (inst_bad || !val_ok) why = `TSC_WHY_RANGE;
				else nak = 1'b0;
			end
			`TSC_OP_ASM_CLEAR, `TSC_OP_ASM_COMMIT, `TSC_OP_QUERY: begin
				// RL13: header must be zero
				if (!hdr_zero) why = `TSC_WHY_HEADER;
				else nak = 1'b0;
			end
			`TSC_OP_ASM_APPEND: begin
				// RL17: header and strings checked
				if ((cmd.item != 8'h00) || (cmd.inst != 8'h00)) why = `TSC_WHY_HEADER;
				// RL15: append needs prior clear
				else if (!started_reg) why = `TSC_WHY_NOT_STARTED;
				// RL16: two to four strings expected
				else if (!scan.ok) why = `TSC_WHY_STRINGS;
				else if (asm_full) why = `TSC_WHY_FULL;
				else nak = 1'b0;
			end
			default: why = `TSC_WHY_UNKNOWN;
		endcase
	end

	// read-back payload of a get
	logic [255:0] get_buf;
	logic [7:0] get_len;
	always_comb begin
		get_buf = '0;
		get_len = `TSC_LEN_BYTE;
		unique case (cmd.item)
			`TSC_ITEM_ACTION: get_buf[7:0] = set_reg.post_test_action_setting;
			`TSC_ITEM_SYS_FLAGS: begin
				get_buf[15:0] = {set_reg.system_settings_flags[7:0], set_reg.system_settings_flags[15:8]};
				get_len = `TSC_LEN_HALF;
			end
			`TSC_ITEM_LOCK: begin
				get_buf[15:0] = {set_reg.lock_flag_word[7:0], set_reg.lock_flag_word[15:8]};
				get_len = `TSC_LEN_HALF;
			end
			`TSC_ITEM_POLICY: get_buf[7:0] = set_reg.test_choice_policy;
			`TSC_ITEM_FIXED: get_buf[7:0] = set_reg.fixed_test_index;
			`TSC_ITEM_VERDICT_TITLE: begin
				get_buf = verdict_title_reg;
				get_len = verdict_len_reg;
			end
			`TSC_ITEM_PRODUCT_TITLE: begin
				get_buf = product_title_reg;
				get_len = product_len_reg;
			end
			`TSC_ITEM_PRINTER: get_buf[7:0] = set_reg.printer_speed_select;
			`TSC_ITEM_MEM_SET: begin
				get_buf[159:0] = mem_set_reg[inst_idx];
				get_len = `TSC_STRUCT_LEN;
			end
			`TSC_ITEM_MEM_NAME: begin
				get_buf[127:0] = mem_name_reg[inst_idx];
				get_len = mem_len_reg[inst_idx];
			end
			`TSC_ITEM_POWER_ON: get_buf[7:0] = set_reg.power_on_memory_choice;
			default: get_len = 8'h00;
		endcase
	end

	wire ok_go = cmd_go & ~nak;
	wire do_get = ok_go & (cmd.op == `TSC_OP_GET);
	wire do_set = ok_go & (cmd.op == `TSC_OP_SET);
	wire do_clear = ok_go & (cmd.op == `TSC_OP_ASM_CLEAR);
	wire do_append = ok_go & (cmd.op == `TSC_OP_ASM_APPEND);
	wire do_commit = ok_go & (cmd.op == `TSC_OP_ASM_COMMIT);
	wire do_query = ok_go & (cmd.op == `TSC_OP_QUERY);
	wire commit_end = busy & ce & commit_done;
	wire [15:0] input_flags = {15'h0000, guard_sync_reg};

	assign settings = set_reg;
	assign commit_req = busy;
	assign asm_count = count_reg;

	// ----------------------------------------
	// guard switch synchroniser
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			guard_meta_reg <= 1'b0;
			guard_sync_reg <= 1'b0;
		end else if (ce) begin
			guard_meta_reg <= guard_pin;
			guard_sync_reg <= guard_meta_reg;
		end
	end

	// apb read data, captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prdata <= 32'h00000000;
		else if (setup && !pwrite) prdata <= rd_word;
	end

	// ----------------------------------------
	// session, reply and commit sequencing
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= TSC_ST_IDLE;
			reply_reg <= TSC_REPLY_NONE;
			reason_reg <= `TSC_WHY_NONE;
			reply_len_reg <= 8'h00;
			free_reg <= 1'b0;
		end else if (ce) begin
			if (access && pwrite && hit_session) free_reg <= pwdata[`TSC_SESSION_FREE_BIT];
			if (cmd_go) begin
				reason_reg <= why;
				reply_len_reg <= do_get ? get_len : (do_query ? `TSC_LEN_HALF : 8'h00);
				reply_reg <= nak ? TSC_REPLY_NAK : (do_commit ? TSC_REPLY_INTERIM : TSC_REPLY_ACK);
				// RL18: interim reply, then flash write
				if (do_commit) state_reg <= TSC_ST_COMMIT;
			end else if (commit_end) begin
				// RL18: final reply after flash
				reply_reg <= commit_ok ? TSC_REPLY_ACK : TSC_REPLY_NAK;
				reason_reg <= commit_ok ? `TSC_WHY_NONE : `TSC_WHY_FLASH;
				state_reg <= TSC_ST_IDLE;
			end
		end
	end

	// ----------------------------------------
	// payload buffer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) buf_reg <= '0;
		else if (buf_wr) buf_reg[buf_bit +: 32] <= pwdata;
		else if (do_get) buf_reg <= get_buf;
		// RL19: two flag bytes, high first
		else if (do_query) buf_reg <= {240'h0, input_flags[7:0], input_flags[15:8]};
	end

	// ----------------------------------------
	// settings storage
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			set_reg <= '0;
			verdict_title_reg <= '0;
			product_title_reg <= '0;
			verdict_len_reg <= 8'h00;
			product_len_reg <= 8'h00;
			for (int i = 0; i < `TSC_MEM_COUNT; i++) begin
				mem_set_reg[i] <= '0;
				mem_name_reg[i] <= '0;
				mem_len_reg[i] <= 8'h00;
			end
		end else if (do_set) begin
			// RL1: only reached in a free session
			unique case (cmd.item)
				`TSC_ITEM_ACTION: set_reg.post_test_action_setting <= val8;
				`TSC_ITEM_SYS_FLAGS: set_reg.system_settings_flags <= val16;
				`TSC_ITEM_LOCK: set_reg.lock_flag_word <= val16;
				`TSC_ITEM_POLICY: set_reg.test_choice_policy <= val8;
				`TSC_ITEM_FIXED: set_reg.fixed_test_index <= val8;
				`TSC_ITEM_VERDICT_TITLE: begin
					verdict_title_reg <= buf_reg;
					verdict_len_reg <= cmd.len;
				end
				`TSC_ITEM_PRODUCT_TITLE: begin
					product_title_reg <= buf_reg;
					product_len_reg <= cmd.len;
				end
				`TSC_ITEM_PRINTER: set_reg.printer_speed_select <= val8;
				`TSC_ITEM_MEM_SET: mem_set_reg[inst_idx] <= buf_reg[159:0];
				`TSC_ITEM_MEM_NAME: begin
					mem_name_reg[inst_idx] <= buf_reg[127:0];
					mem_len_reg[inst_idx] <= cmd.len;
				end
				default: set_reg.power_on_memory_choice <= val8;
			endcase
		end
	end

	// ----------------------------------------
	// testfile assembly area
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			started_reg <= 1'b0;
			count_reg <= 5'h00;
		end else if (do_clear) begin
			// RL13: empty the assembly area
			started_reg <= 1'b1;
			count_reg <= 5'h00;
		end else if (do_append) begin
			// RL15: one record appended
			count_reg <= count_reg + 5'h01;
		end
	end

	// record storage and flash read port
	always_ff @(posedge pclk) begin
		if (do_append) begin
			asm_rec_mem[count_reg[3:0]] <= buf_reg;
			asm_len_mem[count_reg[3:0]] <= cmd.len;
		end
		if (ce) flash_rd_rec <= asm_rec_mem[flash_rd_idx];
		if (ce) flash_rd_len <= asm_len_mem[flash_rd_idx];
	end

endmodule : tsc_cmd_handler

// ==== inc/tsc_defs.svh ====
// Purpose: constants of the tester settings command handler
// Assumes: included by its bare name
// Notes: definitions only
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// ----------------------------------------
// apb register map (byte addresses)
// ----------------------------------------
`define TSC_ADDR_CMD 12'h000
`define TSC_ADDR_STATUS 12'h004
`define TSC_ADDR_SESSION 12'h008
`define TSC_ADDR_ASM_COUNT 12'h00c
`define TSC_ADDR_BUF_BASE 12'h020
`define TSC_ADDR_BUF_MASK 12'hfe0
`define TSC_SESSION_FREE_BIT 0

// ----------------------------------------
// command codes
// ----------------------------------------
`define TSC_OP_GET 8'h01
`define TSC_OP_SET 8'h02
`define TSC_OP_ASM_CLEAR 8'h30
`define TSC_OP_ASM_APPEND 8'h31
`define TSC_OP_ASM_COMMIT 8'h32
`define TSC_OP_QUERY 8'h80

// ----------------------------------------
// settings item ids
// ----------------------------------------
`define TSC_ITEM_ACTION 8'h33
`define TSC_ITEM_SYS_FLAGS 8'h34
`define TSC_ITEM_LOCK 8'h35
`define TSC_ITEM_POLICY 8'h36
`define TSC_ITEM_FIXED 8'h37
`define TSC_ITEM_VERDICT_TITLE 8'h38
`define TSC_ITEM_PRODUCT_TITLE 8'h39
`define TSC_ITEM_PRINTER 8'h3a
`define TSC_ITEM_MEM_SET 8'h3b
`define TSC_ITEM_MEM_NAME 8'h3c
`define TSC_ITEM_POWER_ON 8'h3d

// ----------------------------------------
// value limits and lengths
// ----------------------------------------
`define TSC_ACTION_MAX 8'h02
`define TSC_POLICY_MAX 8'h02
`define TSC_FIXED_MAX 8'h13
`define TSC_PRINTER_MAX 8'h01
`define TSC_MEM_MAX 8'h09
`define TSC_MEM_COUNT 10
`define TSC_TITLE_MAX 8'h1e
`define TSC_NAME_MAX 8'h10
`define TSC_STRUCT_LEN 8'h14
`define TSC_LEN_BYTE 8'h01
`define TSC_LEN_HALF 8'h02
`define TSC_ENTRY_MIN 6'h02
`define TSC_ENTRY_MAX 6'h04
`define TSC_ENTRY_STR_MAX 8'h14
`define TSC_ASM_DEPTH 16
`define TSC_ASM_FULL 5'h10
`define TSC_GUARD_BIT 0

// ----------------------------------------
// negative reply reason codes
// ----------------------------------------
`define TSC_WHY_NONE 8'h00
`define TSC_WHY_HEADER 8'h01
`define TSC_WHY_LOCKED 8'h02
`define TSC_WHY_RANGE 8'h03
`define TSC_WHY_NOT_STARTED 8'h04
`define TSC_WHY_STRINGS 8'h05
`define TSC_WHY_FLASH 8'h06
`define TSC_WHY_UNKNOWN 8'h07
`define TSC_WHY_FULL 8'h08

`endif

// ==== inc/tsc_pkg.sv ====
// Purpose: types of the tester settings command handler
// Assumes: nothing
// Notes: packed carriers for command, settings and scan results
package tsc_pkg;

	// ----------------------------------------
	// command word written by software
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] len;
		logic [7:0] inst;
		logic [7:0] item;
		logic [7:0] op;
	} tsc_cmd_t;

	typedef struct packed {
		logic [3:0] spare;
		logic lock_label_lists;
		logic lock_upload_erase;
		logic lock_result_erase;
		logic lock_result_transfer;
		logic lock_host_operation;
		logic lock_hand_operation;
		logic lock_place_switch;
		logic lock_user_switch;
		logic lock_phonebook_editing;
		logic lock_place_editing;
		logic lock_user_editing;
		logic lock_clock_setting;
	} tsc_lock_t;

	typedef struct packed {
		logic [14:0] spare;
		logic date_month_first;
	} tsc_sys_t;

	typedef struct packed {
		logic [7:0] post_test_action_setting;
		tsc_sys_t system_settings_flags;
		tsc_lock_t lock_flag_word;
		logic [7:0] test_choice_policy;
		logic [7:0] fixed_test_index;
		logic [7:0] printer_speed_select;
		logic [7:0] power_on_memory_choice;
	} tsc_settings_t;

	typedef struct packed {
		logic ok;
		logic [5:0] count;
	} tsc_scan_t;

	typedef enum logic [1:0] {
		TSC_REPLY_NONE = 2'b00,
		TSC_REPLY_ACK = 2'b01,
		TSC_REPLY_INTERIM = 2'b10,
		TSC_REPLY_NAK = 2'b11
	} tsc_reply_t;

	typedef enum logic {
		TSC_ST_IDLE = 1'b0,
		TSC_ST_COMMIT = 1'b1
	} tsc_state_t;

endpackage : tsc_pkg

// ==== verif/tsc_cmd_handler_properties.sv ====
// Purpose: concurrent checks on the settings command handler ports
// Assumes: single pclk domain, presetn async active low
// Notes: session state is rebuilt here from apb writes
`include "tsc_defs.svh"
`timescale 1ns/1ps
module tsc_cmd_handler_properties
	import tsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire tsc_settings_t settings,
	input wire logic commit_req,
	input wire logic commit_done,
	input wire logic [4:0] asm_count
);
	// ----------------------------------------
	// helper decode
	// ----------------------------------------
	wire logic wr_acc = psel & penable & pwrite & ce;
	wire logic cmd_go = wr_acc & (paddr == `TSC_ADDR_CMD) & !commit_req;
	wire logic set_go = cmd_go & (pwdata[7:0] == `TSC_OP_SET);
	logic free_reg;

	// shadow of the session bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			free_reg <= 1'b0;
		else if (wr_acc && paddr == `TSC_ADDR_SESSION)
			free_reg <= pwdata[`TSC_SESSION_FREE_BIT];
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_commit_cmd;
		cmd_go && pwdata == 32'h00000032;
	endsequence
	sequence s_flash_done;
		commit_req && commit_done && ce;
	endsequence

	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_locked_keeps: assert property (set_go && !free_reg |=> $stable(settings))
		else $error("settings changed in restricted session");
	a_set_cause: assert property (!$stable(settings) |-> $past(set_go) && $past(free_reg))
		else $error("settings changed without a permitted set");
	a_action_range: assert property (settings.post_test_action_setting <= `TSC_ACTION_MAX)
		else $error("post test action out of range");
	a_policy_range: assert property (settings.test_choice_policy <= `TSC_POLICY_MAX)
		else $error("test choice policy out of range");
	a_fixed_range: assert property (settings.fixed_test_index <= `TSC_FIXED_MAX)
		else $error("fixed test index out of range");
	a_speed_range: assert property (settings.printer_speed_select <= `TSC_PRINTER_MAX)
		else $error("printer speed out of range");
	a_memory_range: assert property (settings.power_on_memory_choice <= `TSC_MEM_MAX)
		else $error("power on memory out of range");
	a_commit_start: assert property (s_commit_cmd |=> commit_req)
		else $error("commit request not raised");
	a_commit_end: assert property (s_flash_done |=> !commit_req)
		else $error("commit request not dropped");
	a_busy_refused: assert property (wr_acc && paddr == `TSC_ADDR_CMD && commit_req |-> pslverr)
		else $error("command accepted while busy");
	a_clear_empty: assert property (cmd_go && pwdata == 32'h00000030 |=> asm_count == 5'h00)
		else $error("assembly not emptied");
	a_count_step: assert property (!(cmd_go && pwdata[7:0] == `TSC_OP_ASM_CLEAR)
		|=> asm_count == $past(asm_count) || asm_count == $past(asm_count) + 5'h01)
		else $error("assembly count jumped");
endmodule : tsc_cmd_handler_properties

// ==== verif/tsc_flash_model.sv ====
// Purpose: flash writer answering commit requests
// Assumes: shares pclk with the handler
// Notes: delay and result are set by the bench
`timescale 1ns/1ps
module tsc_flash_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic commit_req,
	input wire logic [7:0] delay,
	input wire logic result_ok,
	output logic commit_done,
	output logic commit_ok
);
	logic [7:0] wait_reg;
	wire logic fire = commit_req && wait_reg == delay;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_reg <= 8'h00;
			commit_done <= 1'b0;
			commit_ok <= 1'b0;
		end else begin
			wait_reg <= commit_req ? wait_reg + 8'h01 : 8'h00;
			commit_done <= fire;
			commit_ok <= fire ? result_ok : ~commit_ok;
		end
	end
endmodule : tsc_flash_model

// ==== verif/tsc_cmd_handler_tb_top.sv ====
// Purpose: self-checking bench of the settings command handler
// Assumes: apb master, flash model on the commit side
// Notes: replies, settings and count follow an integer model
`include "tsc_defs.svh"
`timescale 1ns/1ps
module tsc_cmd_handler_tb_top
	import tsc_pkg::*;
;
	logic pclk, presetn, ce, psel, penable, pwrite, guard_pin, fl_ok, pready, pslverr, err;
	logic commit_req, commit_done, commit_ok;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [3:0] flash_rd_idx;
	logic [4:0] asm_count;
	logic [7:0] fl_delay, flash_rd_len;
	logic [255:0] flash_rd_rec;
	tsc_settings_t settings;
	int errors, n_checks, sess, started, asm_n;
	int mv[int];
	int lo_t[11] = '{1, 2, 2, 1, 1, 1, 1, 1, 20, 1, 1};
	int hi_t[11] = '{1, 2, 2, 1, 1, 30, 30, 1, 20, 16, 1};
	int vm_t[11] = '{2, 65535, 65535, 2, 19, 0, 0, 1, 0, 0, 9};
	int im_t[11] = '{0, 0, 0, 0, 0, 0, 0, 0, 9, 9, 0};

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	tsc_cmd_handler i_tsc_cmd_handler (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .guard_pin, .settings, .commit_req, .commit_done, .commit_ok, .flash_rd_idx,
		.flash_rd_rec, .flash_rd_len, .asm_count);
	tsc_flash_model i_tsc_flash_model (.pclk, .presetn, .commit_req, .delay(fl_delay), .result_ok(fl_ok),
		.commit_done, .commit_ok);

	// ----------------------------------------
	// helpers and model
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic chk(input logic [87:0] seen, input logic [87:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	function automatic int judge(int op, int it, int in, int ln, int v);
		int k;
		k = it - 'h33;
		if (op == 1 || op == 2) begin
			if (k < 0 || k > 10)
				return 7;
			if (op == 1)
				return 0;
			if (!sess)
				return 2;
			if (in > im_t[k] || ln < lo_t[k] || ln > hi_t[k] || v > vm_t[k])
				return 3;
			if (hi_t[k] < 3 && im_t[k] == 0)
				mv[it] = v;
			return 0;
		end
		if (op == 'h31) begin
			if (it != 0 || in != 0)
				return 1;
			if (!started)
				return 4;
			if (v < 2 || v > 4)
				return 5;
			asm_n++;
			return 0;
		end
		if (op != 'h30 && op != 'h32 && op != 'h80)
			return 7;
		if (it != 0 || in != 0 || ln != 0)
			return 1;
		if (op == 'h30) begin
			started = 1;
			asm_n = 0;
		end
		return 0;
	endfunction : judge

	task automatic cmd(input int op, input int it, input int in, input int ln, input int v);
		int why;
		why = judge(op, it, in, ln, v);
		apb(1'b1, `TSC_ADDR_CMD, {8'(ln), 8'(in), 8'(it), 8'(op)});
		if (op == 'h32 && why == 0) begin
			apb(1'b0, `TSC_ADDR_STATUS, 32'h0);
			chk(rd[2:0], 3'b110, "interim");
			apb(1'b1, `TSC_ADDR_CMD, 32'h00000080);
			chk(err, 1'b1, "busy refusal");
			while (commit_req !== 1'b0)
				@(posedge pclk);
			why = fl_ok ? 0 : 6;
		end
		apb(1'b0, `TSC_ADDR_STATUS, 32'h0);
		chk({rd[15:8], rd[1:0]}, {8'(why), (why != 0) ? 2'd3 : 2'd1}, "reply");
		chk(settings, {8'(mv['h33]), 16'(mv['h34]), 16'(mv['h35]), 8'(mv['h36]), 8'(mv['h37]),
			8'(mv['h3a]), 8'(mv['h3d])}, "settings");
		chk(asm_count, 5'(asm_n), "count");
	endtask : cmd

	task automatic put(input int it, input int ln, input int v);
		apb(1'b1, `TSC_ADDR_BUF_BASE, (ln == 2) ? {16'h0000, 8'(v), 8'(v >> 8)} : 32'(v));
		cmd(2, it, 0, ln, v);
	endtask : put

	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		errors = 0;
		n_checks = 0;
		seed = 32'hba84;
		{ce, psel, penable, pwrite, paddr, pwdata, guard_pin, flash_rd_idx, presetn} = '0;
		ce = 1'b1;
		fl_delay = 8'h0c;
		fl_ok = 1'b1;
		for (int i = 'h33; i <= 'h3d; i++)
			mv[i] = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h010, 32'h0);
		chk(err, 1'b1, "unmapped");
		put('h33, 1, 1);
		cmd(1, 'h33, 0, 0, 0);
		apb(1'b1, `TSC_ADDR_SESSION, 32'h1);
		sess = 1;
		ce <= 1'b0;
		apb(1'b1, `TSC_ADDR_SESSION, 32'h0);
		ce <= 1'b1;
		apb(1'b0, `TSC_ADDR_SESSION, 32'h0);
		chk(rd[0], 1'b1, "frozen session");
		for (int k = 0; k < 11; k++) begin
			if (hi_t[k] < 3 && im_t[k] == 0) begin
				put('h33 + k, lo_t[k], rnd() % (vm_t[k] + 1));
				put('h33 + k, lo_t[k], vm_t[k]);
				put('h33 + k, 1, (vm_t[k] < 255) ? vm_t[k] + 1 : 5);
			end
		end
		cmd(2, 'h32, 0, 1, 0);
		cmd('h40, 0, 0, 0, 0);
		for (int i = 0; i < 8; i++)
			apb(1'b1, `TSC_ADDR_BUF_BASE + 12'(4 * i), 32'h41414141);
		cmd(2, 'h38, 0, 30, 0);
		cmd(2, 'h38, 0, 31, 0);
		cmd(2, 'h39, 0, 30, 0);
		cmd(2, 'h39, 0, 31, 0);
		cmd(2, 'h3b, 9, 20, 0);
		cmd(2, 'h3b, 0, 19, 0);
		cmd(2, 'h3b, 10, 20, 0);
		cmd(2, 'h3c, 9, 16, 0);
		cmd(2, 'h3c, 9, 17, 0);
		cmd(2, 'h3c, 10, 4, 0);
		apb(1'b1, `TSC_ADDR_SESSION, 32'h0);
		sess = 0;
		put('h34, 2, 1);
		cmd(1, 'h33, 0, 0, 0);
		chk(rd[23:16], 8'h01, "get length");
		apb(1'b0, `TSC_ADDR_BUF_BASE, 32'h0);
		chk(rd[7:0], 8'(mv['h33]), "get value");
		apb(1'b1, `TSC_ADDR_BUF_BASE, 32'h00410041);
		apb(1'b1, `TSC_ADDR_BUF_BASE + 12'h004, 32'h00410041);
		cmd('h31, 0, 0, 4, 2);
		cmd('h30, 1, 0, 0, 0);
		cmd('h30, 0, 0, 0, 0);
		cmd('h31, 0, 0, 4, 2);
		cmd('h31, 0, 0, 8, 4);
		cmd('h31, 0, 0, 2, 1);
		cmd('h31, 0, 1, 4, 2);
		cmd('h30, 0, 0, 0, 0);
		cmd('h31, 0, 0, 6, 3);
		chk({flash_rd_len, flash_rd_rec[47:0]}, {8'h06, 48'h004100410041}, "record");
		cmd('h32, 0, 0, 1, 0);
		cmd('h32, 0, 0, 0, 0);
		fl_ok <= 1'b0;
		fl_delay <= 8'h28;
		cmd('h32, 0, 0, 0, 0);
		for (int g = 1; g >= 0; g--) begin
			guard_pin <= g[0];
			repeat (4) @(posedge pclk);
			cmd('h80, 0, 0, 0, 0);
			chk(rd[23:16], 8'h02, "query length");
			apb(1'b0, `TSC_ADDR_BUF_BASE, 32'h0);
			chk(rd[15:0], {7'h00, g[0], 8'h00}, "guard flags");
		end
		cmd('h80, 0, 0, 2, 0);
		conclude();
	end

	initial begin
		#1000000;
		errors++;
		conclude();
	end
endmodule : tsc_cmd_handler_tb_top

bind tsc_cmd_handler tsc_cmd_handler_properties i_tsc_cmd_handler_properties (.pclk, .presetn, .ce, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pslverr, .settings, .commit_req, .commit_done, .asm_count);
